//--- src/fwsr_ctrl.sv
// Host controller that issues flash commands and polls write status.
module fwsr_ctrl import fwsr_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Software register port.
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Flash pins.
  output fwsr_pin_type flash_pins,
  input wire logic [15:0] flash_dq_i,
  input wire logic ready_busy_n
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEQ = 3'b001,
    S_POLL = 3'b011,
    S_FINAL = 3'b010,
    S_RESET = 3'b110,
    S_SUSP_WAIT = 3'b111
  } fwsr_state_type;

  fwsr_state_type state_ff;
  fwsr_op_type op_ff;
  logic [16:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [16:0] poll_addr_ff;
  logic [16:0] erase_addr_ff;
  logic [15:0] rdata_ff;
  logic [15:0] first_rd_ff;
  logic [2:0] step_ff;
  logic wait_ff;
  logic pair_ff;
  logic recheck_ff;
  logic susp_pend_ff;
  logic sector_erase_ff;
  logic [9:0] susp_cnt_ff;
  logic done_ff, fail_ff, prot_ff, susp_ff, tog2_ff, refused_ff;
  logic [16:0] sync_bus;
  logic [15:0] dq_sync;
  logic rdy_sync;
  logic cyc_start, cyc_done;
  logic [15:0] cyc_rdata;
  fwsr_cyc_type cyc;
  fwsr_op_type req_op;
  logic start_ok, req_wr, toggling;
  logic [2:0] seq_last;

  fwsr_sync #(.W(17)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({ready_busy_n, flash_dq_i}),
    .sync_out(sync_bus)
  );

  assign rdy_sync = sync_bus[16];
  assign dq_sync = sync_bus[15:0];

  fwsr_bus_cycle u_cycle (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(cyc_start),
    .cyc(cyc),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .dq_sync(dq_sync),
    .pins(flash_pins)
  );

  // Command sequence lookup; unlock cycles carry zero upper bits and byte.
  function automatic fwsr_cyc_type seq_cycle(fwsr_op_type op,
      logic [2:0] step, logic [16:0] a, logic [15:0] d);
    fwsr_cyc_type c;
    c = '{rd: 1'b0, addr: UNLOCK_A1, data: UNLOCK_D1};
    if (step == 3'd1 || step == 3'd4) begin
      c.addr = UNLOCK_A2;
      c.data = UNLOCK_D2;
    end
    unique case (op)
      OP_ARRAY_READ: c = '{rd: 1'b1, addr: a, data: 16'h0000};
      OP_PROGRAM: begin
        if (step == 3'd2) c.data = CMD_PROGRAM;
        if (step == 3'd3) c = '{rd: 1'b0, addr: a, data: d};
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
        if (step == 3'd2) c.data = CMD_ERASE;
        if (step == 3'd5) begin
          c.data = (op == OP_CHIP_ERASE) ? CMD_CHIP : CMD_SECTOR;
          if (op == OP_SECTOR_ERASE) begin
            c.addr = {a[SECT_HI:SECT_LO], 12'h000};
          end
        end
      end
      OP_SUSPEND: c.data = CMD_SUSPEND;
      OP_RESUME: c.data = CMD_RESUME;
      OP_RESET: c.data = CMD_RESET;
      OP_READ_ID, OP_PROT_VERIFY: begin
        if (step == 3'd2) c.data = CMD_AUTOSEL;
        if (step == 3'd3) begin
          // The fourth autoselect cycle is a read.
          c.rd = 1'b1;
          c.data = 16'h0000;
          c.addr = (op == OP_READ_ID) ? ID_ADDR :
                   {a[SECT_HI:SECT_LO], PROT_LOW};
        end
      end
      default: c = '{rd: 1'b1, addr: a, data: 16'h0000};
    endcase
    return c;
  endfunction

  // Index of the final cycle of each sequence.
  always_comb begin
    unique case (op_ff)
      OP_PROGRAM, OP_READ_ID, OP_PROT_VERIFY: seq_last = 3'd3;
      OP_SECTOR_ERASE, OP_CHIP_ERASE: seq_last = 3'd5;
      default: seq_last = 3'd0;
    endcase
  end

  // Cycle selection by state; polling always reads the valid address.
  always_comb begin
    cyc = seq_cycle(op_ff, step_ff, addr_ff, wdata_ff);
    if (state_ff == S_POLL || state_ff == S_FINAL) begin
      cyc = '{rd: 1'b1, addr: poll_addr_ff, data: 16'h0000};
    end else if (state_ff == S_RESET) begin
      cyc = '{rd: 1'b0, addr: UNLOCK_A1, data: CMD_RESET};
    end
  end

  assign cyc_start = !wait_ff && state_ff != S_IDLE &&
                     state_ff != S_SUSP_WAIT;
  assign toggling = first_rd_ff[TOG1_BIT] ^ cyc_rdata[TOG1_BIT];

  // Acceptance of software orders, gated by the suspend state.
  assign req_wr = sw_wr && sw_addr == REG_CTRL;
  assign req_op = fwsr_op_type'(sw_wdata[3:0]);
  always_comb begin
    start_ok = 1'b0;
    if (state_ff == S_IDLE) begin
      unique case (req_op)
        OP_ARRAY_READ, OP_PROGRAM, OP_READ_ID, OP_PROT_VERIFY,
        OP_RESET: start_ok = 1'b1;
        OP_SECTOR_ERASE, OP_CHIP_ERASE: start_ok = !susp_ff;
        OP_RESUME: start_ok = susp_ff;
        default: start_ok = 1'b0;
      endcase
    end
  end

  // Register writes for location and value, taken only while idle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_ff <= 17'h0_0000;
      wdata_ff <= 16'h0000;
    end else if (sw_wr && state_ff == S_IDLE) begin
      if (sw_addr == REG_ADDR) addr_ff <= sw_wdata[16:0];
      if (sw_addr == REG_WDATA) wdata_ff <= sw_wdata[15:0];
    end
  end

  // Main sequencer: command cycles, toggle polling, suspend and reset.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= S_IDLE;
      op_ff <= OP_NONE;
      step_ff <= 3'd0;
      wait_ff <= 1'b0;
      pair_ff <= 1'b0;
      recheck_ff <= 1'b0;
      first_rd_ff <= 16'h0000;
      poll_addr_ff <= 17'h0_0000;
      erase_addr_ff <= 17'h0_0000;
      susp_cnt_ff <= 10'd0;
    end else begin
      if (cyc_start) wait_ff <= 1'b1;
      if (cyc_done) wait_ff <= 1'b0;
      unique case (state_ff)
        S_IDLE: begin
          if (req_wr && start_ok) begin
            op_ff <= req_op;
            step_ff <= 3'd0;
            state_ff <= S_SEQ;
            recheck_ff <= 1'b0;
            pair_ff <= 1'b0;
            if (req_op == OP_PROGRAM || req_op == OP_CHIP_ERASE) begin
              poll_addr_ff <= addr_ff;
            end else if (req_op == OP_SECTOR_ERASE) begin
              poll_addr_ff <= addr_ff;
              erase_addr_ff <= addr_ff;
            end else if (req_op == OP_RESUME) begin
              poll_addr_ff <= erase_addr_ff;
              op_ff <= OP_SECTOR_ERASE;
              step_ff <= 3'd5;
              // Only the resume write goes out; the erase is polled after.
            end
          end
        end
        S_SEQ: begin
          if (cyc_done) begin
            if (step_ff != seq_last && op_ff != OP_SUSPEND &&
                !(op_ff == OP_SECTOR_ERASE && susp_ff)) begin
              step_ff <= step_ff + 3'd1;
            end else if (op_ff == OP_ARRAY_READ) begin
              state_ff <= S_IDLE;
            end else if (op_ff == OP_READ_ID || op_ff == OP_PROT_VERIFY ||
                         op_ff == OP_RESET) begin
              state_ff <= (op_ff == OP_RESET) ? S_IDLE : S_RESET;
            end else if (op_ff == OP_SUSPEND) begin
              state_ff <= S_SUSP_WAIT;
              susp_cnt_ff <= SUSP_CYC;
            end else begin
              // Polling starts only after the final strobe has risen.
              state_ff <= S_POLL;
            end
          end
        end
        S_SUSP_WAIT: begin
          // Wait out the worst suspend latency before reading status.
          if (susp_cnt_ff == 10'd1) begin
            state_ff <= S_POLL;
          end else begin
            susp_cnt_ff <= susp_cnt_ff - 10'd1;
          end
        end
        S_POLL: begin
          if (cyc_done) begin
            pair_ff <= !pair_ff;
            first_rd_ff <= cyc_rdata;
            if (pair_ff) begin
              if (!toggling) begin
                state_ff <= S_FINAL;
              end else if (recheck_ff) begin
                state_ff <= S_RESET;
              end else if (cyc_rdata[TFAIL_BIT]) begin
                recheck_ff <= 1'b1;
              end else if (susp_pend_ff && sector_erase_ff) begin
                op_ff <= OP_SUSPEND;
                state_ff <= S_SEQ;
              end
            end
          end
        end
        S_FINAL: begin
          if (cyc_done) state_ff <= S_IDLE;
        end
        S_RESET: begin
          if (cyc_done) state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Suspend orders are held until the next polling pair; others refused.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      susp_pend_ff <= 1'b0;
      sector_erase_ff <= 1'b0;
    end else begin
      if (state_ff == S_IDLE && req_wr && start_ok) begin
        sector_erase_ff <= req_op == OP_SECTOR_ERASE || req_op == OP_RESUME;
      end else if (state_ff == S_SEQ && op_ff == OP_PROGRAM) begin
        sector_erase_ff <= 1'b0;
      end
      if (req_wr && req_op == OP_SUSPEND && state_ff == S_POLL &&
          sector_erase_ff && !susp_ff) begin
        susp_pend_ff <= 1'b1;
      end else if (state_ff == S_IDLE) begin
        susp_pend_ff <= 1'b0;
      end
    end
  end

  // Result flags; a new order clears done, fail, tog2 and refused, results of the final read set.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      prot_ff <= 1'b0;
      susp_ff <= 1'b0;
      tog2_ff <= 1'b0;
      refused_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      if (req_wr && !start_ok && !(req_op == OP_SUSPEND &&
          state_ff == S_POLL && sector_erase_ff)) begin
        refused_ff <= 1'b1;
      end else if (req_wr && start_ok) begin
        refused_ff <= 1'b0;
        done_ff <= 1'b0;
        fail_ff <= 1'b0;
        tog2_ff <= 1'b0;
      end
      if (state_ff == S_POLL && cyc_done && pair_ff && sector_erase_ff &&
          (first_rd_ff[TOG2_BIT] ^ cyc_rdata[TOG2_BIT])) begin
        // Sticky, since the closing pair of a finished erase reads array data and never toggles.
        tog2_ff <= 1'b1;
      end
      if (cyc_done && (state_ff == S_FINAL || (state_ff == S_SEQ &&
          cyc.rd))) begin
        rdata_ff <= cyc_rdata;
        done_ff <= 1'b1;
        if (op_ff == OP_PROT_VERIFY) prot_ff <= cyc_rdata[0];
        if (op_ff == OP_PROGRAM && state_ff == S_FINAL) begin
          // A protected location ends with the old value, not the new.
          fail_ff <= cyc_rdata[POLL_BIT] != wdata_ff[POLL_BIT];
        end
        if (op_ff == OP_SUSPEND) begin
          susp_ff <= cyc_rdata[POLL_BIT];
        end else if (op_ff == OP_SECTOR_ERASE || op_ff == OP_CHIP_ERASE) begin
          fail_ff <= !cyc_rdata[POLL_BIT];
          susp_ff <= 1'b0;
        end
      end
      if (state_ff == S_RESET && cyc_done && op_ff != OP_READ_ID &&
          op_ff != OP_PROT_VERIFY) begin
        fail_ff <= 1'b1;
        done_ff <= 1'b1;
      end
      if (state_ff == S_RESET && cyc_done &&
          (op_ff == OP_READ_ID || op_ff == OP_PROT_VERIFY)) begin
        done_ff <= 1'b1;
      end
      if (state_ff == S_SEQ && cyc_done && op_ff == OP_RESET) begin
        done_ff <= 1'b1;
        susp_ff <= 1'b0;
      end
    end
  end

  // Register read port, data in the cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sw_rdata <= 32'h0000_0000;
    end else if (sw_rd) begin
      sw_rdata <= 32'h0000_0000;
      unique case (sw_addr)
        REG_CTRL: sw_rdata[3:0] <= op_ff;
        REG_ADDR: sw_rdata[16:0] <= addr_ff;
        REG_WDATA: sw_rdata[15:0] <= wdata_ff;
        REG_STATUS: begin
          sw_rdata[ST_BUSY] <= state_ff != S_IDLE;
          sw_rdata[ST_DONE] <= done_ff;
          sw_rdata[ST_FAIL] <= fail_ff;
          sw_rdata[ST_PROT] <= prot_ff;
          sw_rdata[ST_SUSP] <= susp_ff;
          sw_rdata[ST_RDY] <= rdy_sync;
          sw_rdata[ST_TOG2] <= tog2_ff;
          sw_rdata[ST_REFUSED] <= refused_ff;
        end
        REG_RDATA: sw_rdata[15:0] <= rdata_ff;
        default: sw_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // fwsr_ctrl

//--- inc/fwsr_pkg.sv
// Package with constants, types and command codes of the flash status controller.
package fwsr_pkg;

  // Clock and pin timing, figures in ns, counts rounded up.
  localparam int CLK_NS = 50;
  localparam int T_SETUP_NS = 50;
  localparam int T_PULSE_NS = 100;
  localparam int T_HOLD_NS = 50;
  localparam int T_OE_NS = 250;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] OE_CYC = 4'((T_OE_NS + CLK_NS - 1) / CLK_NS);

  // Longest suspend latency in us, rounded down to cycles.
  localparam int SUSP_US = 20;
  localparam logic [9:0] SUSP_CYC = 10'(SUSP_US * 1000 / CLK_NS);

  // Software register offsets (byte addresses).
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // Status register bit positions.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_PROT = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_RDY = 5;
  localparam int ST_TOG2 = 6;
  localparam int ST_REFUSED = 7;

  // Status bit positions on the flash data bus.
  localparam int POLL_BIT = 7;
  localparam int TOG1_BIT = 6;
  localparam int TFAIL_BIT = 5;
  localparam int TOG2_BIT = 2;

  // Sector select bits within the word address.
  localparam int SECT_HI = 16;
  localparam int SECT_LO = 12;

  // Command cycle addresses and data, upper byte and upper bits zero.
  localparam logic [16:0] UNLOCK_A1 = 17'h0_0555;
  localparam logic [16:0] UNLOCK_A2 = 17'h0_02aa;
  localparam logic [16:0] ID_ADDR = 17'h0_0000;
  localparam logic [11:0] PROT_LOW = 12'h002;
  localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_ERASE = 16'h0080;
  localparam logic [15:0] CMD_CHIP = 16'h0010;
  localparam logic [15:0] CMD_SECTOR = 16'h0030;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;

  // Operations that software orders through the control register.
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ARRAY_READ = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_SECTOR_ERASE = 4'h3,
    OP_CHIP_ERASE = 4'h4,
    OP_SUSPEND = 4'h5,
    OP_RESUME = 4'h6,
    OP_RESET = 4'h7,
    OP_READ_ID = 4'h8,
    OP_PROT_VERIFY = 4'h9
  } fwsr_op_type;

  // One bus cycle toward the flash.
  typedef struct packed {
    logic rd;
    logic [16:0] addr;
    logic [15:0] data;
  } fwsr_cyc_type;

  // Flash pin outputs.
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [16:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
  } fwsr_pin_type;

endpackage

//--- src/fwsr_sync.sv
// Two-flop synchroniser for the flash pin inputs.
module fwsr_sync import fwsr_pkg::*; #(
  parameter int W = 17
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Asynchronous input and its synchronised copy.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_ff <= '1;
      sync_out <= '1;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // fwsr_sync

//--- src/fwsr_bus_cycle.sv
// Single read or write cycle engine on the flash strobes.
module fwsr_bus_cycle import fwsr_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Cycle request and answer.
  input wire logic start,
  input wire fwsr_cyc_type cyc,
  output logic done,
  output logic [15:0] rdata,
  // Synchronised data bus and pin outputs.
  input wire logic [15:0] dq_sync,
  output fwsr_pin_type pins
);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_PULSE = 2'b11,
    PH_HOLD = 2'b10
  } fwsr_phase_type;

  fwsr_phase_type phase_ff;
  logic [3:0] cnt_ff;
  logic rd_ff;

  // Phase sequencing; address and data stand still across the whole cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_ff <= PH_IDLE;
      cnt_ff <= 4'h0;
      rd_ff <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (phase_ff)
        PH_IDLE: begin
          if (start) begin
            phase_ff <= PH_SETUP;
            cnt_ff <= SETUP_CYC;
            rd_ff <= cyc.rd;
          end
        end
        PH_SETUP: begin
          if (cnt_ff == 4'h1) begin
            phase_ff <= PH_PULSE;
            cnt_ff <= rd_ff ? OE_CYC : PULSE_CYC;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        PH_PULSE: begin
          if (cnt_ff == 4'h1) begin
            phase_ff <= PH_HOLD;
            cnt_ff <= HOLD_CYC;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        PH_HOLD: begin
          if (cnt_ff == 4'h1) begin
            phase_ff <= PH_IDLE;
            done <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
      endcase
    end
  end

  // Pin drive; address is set one phase before the strobes fall.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0,
                dq_oe: 1'b0};
    end else if (phase_ff == PH_IDLE && start) begin
      pins.addr <= cyc.addr;
      pins.dq_o <= cyc.data;
      pins.dq_oe <= !cyc.rd;
    end else if (phase_ff == PH_SETUP && cnt_ff == 4'h1) begin
      // Chip select and strobe fall together so the later edge is known.
      pins.ce_n <= 1'b0;
      pins.we_n <= rd_ff;
      pins.oe_n <= !rd_ff;
    end else if (phase_ff == PH_PULSE && cnt_ff == 4'h1) begin
      // Data stays driven through the hold phase past the rising edges.
      pins.ce_n <= 1'b1;
      pins.we_n <= 1'b1;
      pins.oe_n <= 1'b1;
    end else if (phase_ff == PH_HOLD && cnt_ff == 4'h1) begin
      pins.dq_oe <= 1'b0;
    end
  end

  // Read data is taken on the last cycle of the enable pulse.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (phase_ff == PH_PULSE && cnt_ff == 4'h1 && rd_ff) begin
      rdata <= dq_sync;
    end
  end

endmodule // fwsr_bus_cycle

//--- dv/fwsr_ctrl_monitor.sv
// Assertion checker of the controller's flash strobe timing.
module fwsr_ctrl_monitor import fwsr_pkg::*; (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Flash pins.
  input wire fwsr_pin_type flash_pins
);
  fwsr_pin_type p;
  // A short alias keeps the properties readable.
  assign p = flash_pins;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Tails of the strobe pulses after their falling edge.
  sequence s_wr_tail; !p.we_n ##1 p.we_n; endsequence
  sequence s_rd_tail; !p.oe_n [*4] ##1 p.oe_n; endsequence
  property p_one_strobe; !(!p.we_n && !p.oe_n); endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("strobe clash");
  property p_sel; (!p.we_n || !p.oe_n) |-> !p.ce_n; endproperty
  a_sel: assert property (p_sel)
    else $error("strobe without select");
  property p_wr_len; $fell(p.we_n) |=> s_wr_tail; endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write pulse length");
  property p_rd_len; $fell(p.oe_n) |=> s_rd_tail; endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read pulse length");
  property p_setup; $fell(p.ce_n) |-> $stable(p.addr); endproperty
  a_setup: assert property (p_setup)
    else $error("address setup");
  property p_hold; !p.ce_n && !$past(p.ce_n) |-> $stable(p.addr); endproperty
  a_hold: assert property (p_hold)
    else $error("address moved");
  property p_data; !p.we_n |-> p.dq_oe && $stable(p.dq_o); endproperty
  a_data: assert property (p_data)
    else $error("write data moved");
  property p_no_fight; !p.oe_n |-> !p.dq_oe; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("bus contention");
endmodule // fwsr_ctrl_monitor

bind fwsr_ctrl fwsr_ctrl_monitor u_fwsr_ctrl_monitor (.ref_clk(ref_clk),
  .srst(srst), .flash_pins(flash_pins));

//--- dv/fwsr_flash_model.sv
// Behavioural flash device on the controller's flash pins.
module fwsr_flash_model import fwsr_pkg::*; #(
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 150000,
  parameter int SUSP_NS = 9000,
  parameter logic [4:0] PROT_SECT = 5'h1f,
  // Identity value is arbitrary.
  parameter logic [15:0] MAKER_ID = 16'h005a
) (
  // Pins from the controller.
  input wire fwsr_pin_type pins,
  // Data toward the controller and ready/busy pull-down.
  output logic [15:0] dq,
  output logic rb_pull
);
  logic [15:0] mem [0:131071];
  logic [16:0] la, pa;
  logic [15:0] pv;
  logic [7:0] v;
  logic [4:0] es;
  logic t1 = 0, t2 = 0, sus = 0, chip = 0, sp = 0;
  int n = 0, mode = 0;
  time done_at, sus_at, rem;
  // Modes: 0 array, 1 program, 2 erase, 4 autoselect, 5 timed out.
  assign rb_pull = mode == 1 || mode == 2 || mode == 5;
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    mem[{PROT_SECT, 12'h000}] = 16'h1234;
    dq = 16'h0000;
  end
  // Location taken at the falling write strobe.
  always @(negedge pins.we_n) la = pins.addr;
  // Commands act at the rising strobe; only the low byte counts.
  always @(posedge pins.we_n) begin
    v = pins.dq_o[7:0];
    if (mode == 1 || mode == 2) begin
      if (v == 8'hb0 && mode == 2 && !chip && !sp) begin
        sp = 1;
        sus_at = $time + SUSP_NS;
      end
    end else if (n == 3) begin
      // Taken first: a program value may look like a command byte.
      pa = la;
      pv = pins.dq_o;
      mode = 1;
      n = 0;
      done_at = $time + (la[16:12] == PROT_SECT ? 2000 : PROG_NS);
    end else if (v == 8'hf0) begin
      mode = 0;
      n = 0;
    end else if (v == 8'h30 && sus && n == 0) begin
      mode = 2;
      sus = 0;
      done_at = $time + rem;
    end else if (n == 6 && (v == 8'h30 || v == 8'h10)) begin
      chip = v == 8'h10;
      es = la[16:12];
      mode = 2;
      n = 0;
      done_at = $time + (!chip && es == PROT_SECT ? 100000 : ERASE_NS);
    end else if ((n == 0 || n == 4) && v == 8'haa && la[10:0] == 11'h555)
      n = n + 1;
    else if ((n == 1 || n == 5) && v == 8'h55 && la[10:0] == 11'h2aa)
      n = n + 1;
    else if (n == 2 && v == 8'ha0) n = 3;
    else if (n == 2 && v == 8'h80) n = 4;
    else if (n == 2 && v == 8'h90) begin
      mode = 4;
      n = 0;
    end else n = 0;
  end
  // Embedded operations end on a timer checked every reference period.
  always #50 begin
    if (sp && $time >= sus_at) begin
      sp = 0;
      sus = 1;
      rem = done_at - $time;
      mode = 0;
    end else if (mode == 1 && $time >= done_at) begin
      if ((mem[pa] & pv) != pv) mode = 5;
      else begin
        if (pa[16:12] != PROT_SECT) mem[pa] = pv;
        mode = 0;
      end
    end else if (mode == 2 && $time >= done_at) begin
      foreach (mem[i])
        if ((chip || (i >> 12) == es) && (i >> 12) != PROT_SECT)
          mem[i] = 16'hffff;
      mode = 0;
    end
  end
  // Status replaces array data while an operation owns the address.
  always @(negedge pins.oe_n) begin
    if (mode == 4)
      dq = pins.addr[11:0] == 12'h002 ?
        {15'h0000, pins.addr[16:12] == PROT_SECT} : MAKER_ID;
    else if (mode == 1 || mode == 5) begin
      t1 = !t1;
      dq = {8'h00, !pv[7], t1, mode == 5, 5'h00};
    end else if (mode == 2 || sus && pins.addr[16:12] == es) begin
      if (mode == 2) t1 = !t1;
      if (chip || pins.addr[16:12] == es) t2 = !t2;
      dq = {8'h00, sus, t1, 3'b000, t2, 2'b00};
    end else dq = mem[pins.addr];
  end
  // Released bus shows the inverse of its last value, so no stale match.
  always @(posedge pins.oe_n) dq = ~dq;
endmodule // fwsr_flash_model

//--- dv/test_fwsr_ctrl.sv
// Self-checking bench of the flash status controller.
module test_fwsr_ctrl import fwsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] PS = 5'h1f;
  // Identity value is arbitrary.
  localparam logic [15:0] ID = 16'h00c3;
  logic ref_clk, srst, sw_wr, sw_rd, rb_pull;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, r;
  logic [15:0] fdq, flash_dq_i, d;
  logic [16:0] a;
  fwsr_pin_type pins;
  int miscompares, compares;
  // Pull-up on ready/busy; bus taken from whichever side drives it.
  wire ready_busy_n = !rb_pull;
  assign flash_dq_i = pins.dq_oe ? pins.dq_o : fdq;
  fwsr_ctrl u_fwsr_ctrl (.ref_clk(ref_clk), .srst(srst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .flash_pins(pins), .flash_dq_i(flash_dq_i), .ready_busy_n(ready_busy_n));
  fwsr_flash_model #(.PROT_SECT(PS), .MAKER_ID(ID)) u_fwsr_flash_model (
    .pins(pins), .dq(fdq), .rb_pull(rb_pull));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = !ref_clk;
  end
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] da);
    @(posedge ref_clk);
    sw_addr <= ad;
    sw_wdata <= da;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge ref_clk);
    sw_addr <= ad;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 r = sw_rdata;
  endtask
  // Orders an operation and polls status until busy drops.
  task automatic run(input fwsr_op_type op);
    int k;
    wr(REG_CTRL, {28'h000_0000, op});
    repeat (2) @(posedge ref_clk);
    for (k = 0; k < 20000; k++) begin
      rd(REG_STATUS);
      if (r[ST_BUSY] === 1'b0) break;
    end
    if (k == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic prog(input logic [16:0] ad, input logic [15:0] da);
    wr(REG_ADDR, {15'h0000, ad});
    wr(REG_WDATA, {16'h0000, da});
    run(OP_PROGRAM);
  endtask
  task automatic aread(input logic [16:0] ad, input logic [15:0] exp);
    wr(REG_ADDR, {15'h0000, ad});
    run(OP_ARRAY_READ);
    rd(REG_RDATA);
    chk(r, {16'h0000, exp});
  endtask
  initial begin
    r = $urandom(44992);
    {srst, sw_wr, sw_rd, sw_addr, sw_wdata} = {1'b1, 42'h000_0000_0000};
    miscompares = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(8'h20);
    chk(r, 32'h0000_0000);
    rd(REG_STATUS);
    chk(r, 32'h0000_0020);
    for (int i = 0; i < 3; i++) begin
      a = {5'(1 + $urandom_range(27)), 12'($urandom)};
      d = 16'($urandom) & 16'hfffe;
      prog(a, d);
      chk(r & 32'h0000_0006, 32'h0000_0002);
      aread(a, d);
    end
    prog(a, ~d);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    aread(a, d);
    prog({PS, 12'h0ff}, 16'h0055);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    aread({PS, 12'h0ff}, 16'hffff);
    for (int i = 0; i < 2; i++) begin
      wr(REG_ADDR, {15'h0000, i ? PS : 5'h03, 12'h000});
      run(OP_PROT_VERIFY);
      chk(r & 32'h0000_0008, i ? 32'h0000_0008 : 32'h0000_0000);
    end
    run(OP_READ_ID);
    rd(REG_RDATA);
    chk(r, {16'h0000, ID});
    run(OP_SUSPEND);
    chk(r & 32'h0000_0090, 32'h0000_0080);
    run(OP_RESUME);
    chk(r & 32'h0000_0090, 32'h0000_0080);
    wr(REG_ADDR, {15'h0000, 5'h1e, 12'h010});
    wr(REG_CTRL, {28'h000_0000, OP_SECTOR_ERASE});
    repeat (100) @(posedge ref_clk);
    run(OP_SUSPEND);
    chk(r & 32'h0000_00d1, 32'h0000_0050);
    prog({5'h1d, 12'h020}, 16'h00a5);
    chk(r & 32'h0000_0006, 32'h0000_0002);
    run(OP_RESUME);
    chk(r & 32'h0000_0056, 32'h0000_0042);
    aread({5'h1e, 12'h010}, 16'hffff);
    run(OP_CHIP_ERASE);
    aread({5'h1d, 12'h020}, 16'hffff);
    aread({PS, 12'h000}, 16'h1234);
    run(OP_SECTOR_ERASE);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    tally_and_finish();
  end
endmodule // test_fwsr_ctrl
